// *** rtl/parallel_io_ports.sv ***
// Four parallel I/O ports with shared serial, converter and capture functions.
// Behaviour
// - Direction one drives pin from output latch.
// - Reset clears every implemented direction bit.
// - Reset leaves output data latches unchanged.
// - Port data registers at first four addresses.
// - Output bit reads back its latch.
// - Input bit reads pin level after two-stage synchroniser.
// - Data writes always update output latches.
// - Port A eight pins, direction after data.
// - Port B bits 7-5; fixed fills elsewhere.
// - Serial port uses port B 7-5 pins.
// - Direction writes override serial default directions.
// - Serial disabled: port B plain I/O.
// - Build option picks serial bit order.
// - Converter enabled: port C analog pins.
// - Channel select picks one analog pin.
// - Selected analog pin reads zero digitally.
// - Reset disables converter, port C digital.
// - Port D bit 7 input only, readable.
// - Port D bit 5 bidirectional, own direction.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports #(
    parameter bit msb_first = 1'b1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire parallel_io_pkg::bus_request_s bus_request,
    output logic [7:0] read_data,
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    input wire logic [2:0] port_b_pins_in,
    output logic [2:0] port_b_pins_out,
    output logic [2:0] port_b_pins_oe,
    input wire logic [7:0] port_c_pins_in,
    output logic [7:0] port_c_pins_out,
    output logic [7:0] port_c_pins_oe,
    input wire logic port_d_capture_input_pin,
    input wire logic port_d_bit5_pin_in,
    output logic port_d_bit5_pin_out,
    output logic port_d_bit5_pin_oe,
    input wire logic sync_serial_enable,
    input wire logic sync_serial_master,
    input wire logic sync_serial_clock_out,
    input wire logic sync_serial_data_out,
    output logic sync_serial_clock_in,
    output logic sync_serial_data_in,
    output logic sync_serial_msb_first,
    output logic converter_enable,
    output logic [1:0] converter_channel,
    output logic timer_capture_in
);
    // ----------------------------------------------------------------
    // Pin synchronisers.
    // ----------------------------------------------------------------
    logic [7:0] a_meta, a_pin, c_meta, c_pin;
    logic [2:0] b_meta, b_pin;
    logic [1:0] d_meta, d_pin;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            a_meta <= 8'h00;
            a_pin <= 8'h00;
            b_meta <= 3'h0;
            b_pin <= 3'h0;
            c_meta <= 8'h00;
            c_pin <= 8'h00;
            d_meta <= 2'h0;
            d_pin <= 2'h0;
        end else begin
            a_meta <= port_a_pins_in;
            a_pin <= a_meta;
            b_meta <= port_b_pins_in;
            b_pin <= b_meta;
            c_meta <= port_c_pins_in;
            c_pin <= c_meta;
            d_meta <= {port_d_capture_input_pin, port_d_bit5_pin_in};
            d_pin <= d_meta;
        end
    end

    // ----------------------------------------------------------------
    // Address decode.
    // ----------------------------------------------------------------
    wire logic wr = bus_request.write_strobe;
    wire logic [7:0] addr = bus_request.address;
    wire logic [7:0] wdata = bus_request.write_data;
    wire logic wr_a = wr && addr == parallel_io_pkg::port_a_data_offset;
    wire logic wr_b = wr && addr == parallel_io_pkg::port_b_data_offset;
    wire logic wr_c = wr && addr == parallel_io_pkg::port_c_data_offset;
    wire logic wr_d = wr && addr == parallel_io_pkg::port_d_data_offset;
    wire logic wr_da = wr && addr == parallel_io_pkg::port_a_direction_offset;
    wire logic wr_db = wr && addr == parallel_io_pkg::port_b_direction_offset;
    wire logic wr_dc = wr && addr == parallel_io_pkg::port_c_direction_offset;
    wire logic wr_dd = wr && addr == parallel_io_pkg::port_d_direction_offset;
    wire logic wr_cc = wr && addr == parallel_io_pkg::converter_control_offset;

    // ----------------------------------------------------------------
    // Output data latches, not reset.
    // ----------------------------------------------------------------
    logic [7:0] port_a_data, port_c_data;
    logic [2:0] port_b_data;
    logic port_d_data;

    always_ff @(posedge clock) begin
        if (wr_a) begin
            port_a_data <= wdata;
        end
        if (wr_b) begin
            port_b_data <= wdata[7:5];
        end
        if (wr_c) begin
            port_c_data <= wdata;
        end
        if (wr_d) begin
            port_d_data <= wdata[5];
        end
    end

    // ----------------------------------------------------------------
    // Direction and converter control registers.
    // ----------------------------------------------------------------
    logic [7:0] port_a_direction, port_c_direction, converter_status_control;
    logic [2:0] port_b_direction;
    logic port_d_bit5_direction, serial_was_enabled;
    wire logic serial_rise = sync_serial_enable && !serial_was_enabled;
    wire logic [2:0] serial_default = {sync_serial_master, 1'b0, 1'b1};
    wire logic [2:0] next_port_b_direction =
        wr_db ? wdata[7:5] : (serial_rise ? serial_default : port_b_direction);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port_a_direction <= parallel_io_pkg::direction_reset;
            port_b_direction <= 3'h0;
            port_c_direction <= parallel_io_pkg::direction_reset;
            port_d_bit5_direction <= 1'b0;
            converter_status_control <= parallel_io_pkg::converter_control_reset;
            serial_was_enabled <= 1'b0;
        end else begin
            if (wr_da) begin
                port_a_direction <= wdata;
            end
            if (wr_dc) begin
                port_c_direction <= wdata;
            end
            if (wr_dd) begin
                port_d_bit5_direction <= wdata[5];
            end
            if (wr_cc) begin
                converter_status_control <= wdata;
            end
            port_b_direction <= next_port_b_direction;
            serial_was_enabled <= sync_serial_enable;
        end
    end

    // ----------------------------------------------------------------
    // Analog pin selection.
    // ----------------------------------------------------------------
    wire logic adc_on = converter_status_control[parallel_io_pkg::converter_enable_bit];
    wire logic [1:0] channel = {
        converter_status_control[parallel_io_pkg::channel_select_high],
        converter_status_control[parallel_io_pkg::channel_select_low]};
    wire logic [7:0] analog_pins = adc_on ? 8'hF8 : 8'h00;
    wire logic [7:0] selected_pin;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_select
            assign selected_pin[gi] = adc_on && gi >= parallel_io_pkg::analog_first_pin &&
                gi < parallel_io_pkg::high_reference_pin &&
                channel == 2'(gi - parallel_io_pkg::analog_first_pin);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read multiplexer.
    // ----------------------------------------------------------------
    wire logic [7:0] read_a = (port_a_direction & port_a_data) |
        (~port_a_direction & a_pin);
    wire logic [2:0] read_b3 = (port_b_direction & port_b_data) |
        (~port_b_direction & b_pin);
    wire logic [7:0] read_c_raw = (port_c_direction & port_c_data) |
        (~port_c_direction & c_pin);
    wire logic [7:0] read_c = read_c_raw & ~selected_pin;
    wire logic read_d5 = port_d_bit5_direction ? port_d_data : d_pin[0];
    wire logic [7:0] read_d = {d_pin[1], 1'b0, read_d5, 5'h00} |
        parallel_io_pkg::port_d_data_fill;
    logic [7:0] next_read_data;

    always_comb begin
        next_read_data = 8'h00;
        if (bus_request.read_strobe) begin
            unique case (addr)
                parallel_io_pkg::port_a_data_offset: next_read_data = read_a;
                parallel_io_pkg::port_b_data_offset: next_read_data = {read_b3, 5'h00};
                parallel_io_pkg::port_c_data_offset: next_read_data = read_c;
                parallel_io_pkg::port_d_data_offset: next_read_data = read_d;
                parallel_io_pkg::port_a_direction_offset: next_read_data = port_a_direction;
                parallel_io_pkg::port_b_direction_offset: next_read_data =
                    {port_b_direction, 5'h00} | parallel_io_pkg::port_b_direction_fill;
                parallel_io_pkg::port_c_direction_offset: next_read_data = port_c_direction;
                parallel_io_pkg::port_d_direction_offset: next_read_data =
                    {2'h0, port_d_bit5_direction, 5'h00};
                parallel_io_pkg::converter_control_offset: next_read_data =
                    converter_status_control;
                default: next_read_data = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers and function outputs.
    // ----------------------------------------------------------------
    wire logic [2:0] next_b_out = sync_serial_enable ?
        {sync_serial_master ? sync_serial_clock_out : port_b_data[2], port_b_data[1],
         sync_serial_data_out} : port_b_data;
    logic [2:0] b_out;
    logic [7:0] c_oe;
    wire logic [7:0] next_port_c_oe = port_c_direction & ~analog_pins;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= 8'h00;
            b_out <= 3'h0;
            c_oe <= 8'h00;
            sync_serial_msb_first <= 1'b0;
            converter_enable <= 1'b0;
            converter_channel <= 2'h0;
        end else begin
            read_data <= next_read_data;
            b_out <= next_b_out;
            c_oe <= next_port_c_oe;
            sync_serial_msb_first <= msb_first;
            converter_enable <= adc_on;
            converter_channel <= channel;
        end
    end

    assign port_a_pins_out = port_a_data;
    assign port_a_pins_oe = port_a_direction;
    assign port_b_pins_out = b_out;
    assign port_b_pins_oe = port_b_direction;
    assign port_c_pins_out = port_c_data;
    assign port_c_pins_oe = c_oe;
    assign port_d_bit5_pin_out = port_d_data;
    assign port_d_bit5_pin_oe = port_d_bit5_direction;
    assign sync_serial_clock_in = b_pin[2];
    assign sync_serial_data_in = b_pin[1];
    assign timer_capture_in = d_pin[1];

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    logic [7:0] past_wdata;
    logic past_rd_a, past_wr_a;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            past_wdata <= 8'h00;
            past_rd_a <= 1'b0;
            past_wr_a <= 1'b0;
        end else begin
            past_wdata <= wdata;
            past_rd_a <= bus_request.read_strobe && addr == parallel_io_pkg::port_a_data_offset;
            past_wr_a <= wr_a;
        end
    end

    direction_drives_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_da |=> port_a_pins_oe == $past(wdata))
        else $error("port A enable does not follow direction write");
    reset_dir_a: assert property (@(posedge clock)
        $rose(reset_n) |-> port_a_pins_oe == 8'h00 && port_b_pins_oe == 3'h0 &&
        port_c_pins_oe == 8'h00 && !port_d_bit5_pin_oe)
        else $error("direction not clear after reset");
    latch_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_a && !wr_da |=> port_a_pins_out == past_wdata)
        else $error("port A latch not written");
    unmapped_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr > parallel_io_pkg::converter_control_offset
        |=> read_data == 8'h00)
        else $error("unmapped read not zero");
    read_output_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_a_data_offset
        |=> (read_data & $past(port_a_direction)) ==
            ($past(port_a_data) & $past(port_a_direction)))
        else $error("output bits not read from latch");
    read_input_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_a_data_offset
        |=> (read_data & ~$past(port_a_direction)) ==
            ($past(a_pin) & ~$past(port_a_direction)))
        else $error("input bits not read from pin");
    port_b_fill_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_b_direction_offset
        |=> read_data[4:0] == 5'h1F)
        else $error("port B direction fill wrong");
    adc_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_c_data_offset && adc_on
        |=> read_data[3'($past(channel)) + 3'd3] == 1'b0)
        else $error("selected analog pin reads nonzero");
    port_d_fixed_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_d_data_offset
        |=> read_data[4] && read_data[3:0] == 4'h0 && !read_data[6])
        else $error("port D fixed bits wrong");
    serial_dir_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_db |=> port_b_pins_oe == $past(wdata[7:5]))
        else $error("port B direction write not honoured");
    analog_oe_a: assert property (@(posedge clock) disable iff (!reset_n)
        adc_on |=> (port_c_pins_oe & 8'hF8) == 8'h00)
        else $error("analog pin driver left on");
    serial_default_a: assert property (@(posedge clock) disable iff (!reset_n)
        serial_rise && !wr_db |=> port_b_pins_oe == {$past(sync_serial_master), 2'b01})
        else $error("serial default directions wrong");
    serial_clock_out_a: assert property (@(posedge clock) disable iff (!reset_n)
        sync_serial_enable && sync_serial_master |=>
        port_b_pins_out[2] == $past(sync_serial_clock_out))
        else $error("serial clock not driven in master mode");
    serial_data_out_a: assert property (@(posedge clock) disable iff (!reset_n)
        sync_serial_enable |=> port_b_pins_out[0] == $past(sync_serial_data_out))
        else $error("serial data out not driven");
    plain_port_b_a: assert property (@(posedge clock) disable iff (!reset_n)
        wr_b && !sync_serial_enable ##1 !sync_serial_enable |=>
        port_b_pins_out == $past(port_b_data))
        else $error("port B pins do not follow latch");
    port_d_input_a: assert property (@(posedge clock) disable iff (!reset_n)
        bus_request.read_strobe && addr == parallel_io_pkg::port_d_data_offset
        |=> read_data[7] == $past(timer_capture_in))
        else $error("port D bit 7 does not read the capture pin");

    // ----------------------------------------------------------------
    // Cover properties.
    // ----------------------------------------------------------------
    read_a_c: cover property (@(posedge clock) disable iff (!reset_n) past_wr_a && past_rd_a);
    serial_on_c: cover property (@(posedge clock) disable iff (!reset_n) serial_rise);
    adc_read_c: cover property (@(posedge clock) disable iff (!reset_n)
        adc_on && bus_request.read_strobe && addr == parallel_io_pkg::port_c_data_offset);
    serial_slave_c: cover property (@(posedge clock) disable iff (!reset_n)
        serial_rise && !sync_serial_master);
    port_d_out_c: cover property (@(posedge clock) disable iff (!reset_n)
        port_d_bit5_pin_oe && bus_request.read_strobe &&
        addr == parallel_io_pkg::port_d_data_offset);
endmodule
`default_nettype wire

// *** rtl/parallel_io_pkg.sv ***
// Package with register map, field layout and carrier types of the parallel ports.
package parallel_io_pkg;
    // ----------------------------------------------------------------
    // Register offsets.
    // ----------------------------------------------------------------
    localparam logic [7:0] port_a_data_offset = 8'h00;
    localparam logic [7:0] port_b_data_offset = 8'h01;
    localparam logic [7:0] port_c_data_offset = 8'h02;
    localparam logic [7:0] port_d_data_offset = 8'h03;
    localparam logic [7:0] port_a_direction_offset = 8'h04;
    localparam logic [7:0] port_b_direction_offset = 8'h05;
    localparam logic [7:0] port_c_direction_offset = 8'h06;
    localparam logic [7:0] port_d_direction_offset = 8'h07;
    localparam logic [7:0] converter_control_offset = 8'h08;
    // ----------------------------------------------------------------
    // Implemented bits and fixed read values.
    // ----------------------------------------------------------------
    localparam logic [7:0] port_b_mask = 8'hE0;
    localparam logic [7:0] port_b_direction_fill = 8'h1F;
    localparam logic [7:0] port_d_data_mask = 8'h20;
    localparam logic [7:0] port_d_data_fill = 8'h10;
    localparam logic [7:0] port_d_direction_mask = 8'h20;
    localparam logic [7:0] direction_reset = 8'h00;
    localparam logic [7:0] converter_control_reset = 8'h00;
    localparam int converter_enable_bit = 5;
    localparam int channel_select_high = 1;
    localparam int channel_select_low = 0;
    localparam int analog_first_pin = 3;
    localparam int high_reference_pin = 7;
    localparam int capture_pin = 7;
    // ----------------------------------------------------------------
    // Carrier types.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] address;
        logic [7:0] write_data;
        logic write_strobe;
        logic read_strobe;
    } bus_request_s;
endpackage

// *** dv/pin_load.sv ***
// Model of the circuitry wired to the port pins.
`timescale 1ns/1ps
`default_nettype none
module pin_load #(
    parameter int width = 8
) (
    input wire logic [width-1:0] drive_out,
    input wire logic [width-1:0] drive_oe,
    input wire logic [width-1:0] outside,
    input wire logic heavy_load,
    output logic [width-1:0] level
);
    // ----------------------------------------------------------------
    // Pin level.
    // ----------------------------------------------------------------
    // Driven pins follow the latch unless a heavy load pulls them low.
    assign level = (drive_oe & (heavy_load ? '0 : drive_out)) | (~drive_oe & outside);
endmodule
`default_nettype wire

// *** dv/parallel_io_ports_tb.sv ***
// Self-checking testbench of the parallel ports.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    parallel_io_pkg::bus_request_s bus_request = '0;
    logic [7:0] read_data, seen;
    logic [7:0] a_out, a_oe, a_level, c_out, c_oe, c_level;
    logic [7:0] a_outside = 8'h3C;
    logic [7:0] c_outside = 8'hFF;
    logic [2:0] b_out, b_oe, b_level;
    logic [2:0] b_outside = 3'h0;
    logic d5_out, d5_oe, d5_level, ser_clk_in, ser_data_in, ser_msb, conv_en, cap_in;
    logic [1:0] conv_ch;
    logic cap_pin = 1'b0;
    logic d5_outside = 1'b0;
    logic heavy = 1'b0;
    logic ser_en = 1'b0;
    logic ser_master = 1'b0;
    logic ser_clk = 1'b0;
    logic ser_data = 1'b0;
    int bad_count = 0;
    int checks = 0;

    // ----------------------------------------------------------------
    // Design and pin circuitry.
    // ----------------------------------------------------------------
    parallel_io_ports #(.msb_first(1'b1)) parallel_io_ports_inst (
        .clock(clock), .reset_n(reset_n), .bus_request(bus_request), .read_data(read_data),
        .port_a_pins_in(a_level), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe),
        .port_b_pins_in(b_level), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe),
        .port_c_pins_in(c_level), .port_c_pins_out(c_out), .port_c_pins_oe(c_oe),
        .port_d_capture_input_pin(cap_pin), .port_d_bit5_pin_in(d5_level),
        .port_d_bit5_pin_out(d5_out), .port_d_bit5_pin_oe(d5_oe),
        .sync_serial_enable(ser_en), .sync_serial_master(ser_master),
        .sync_serial_clock_out(ser_clk), .sync_serial_data_out(ser_data),
        .sync_serial_clock_in(ser_clk_in), .sync_serial_data_in(ser_data_in),
        .sync_serial_msb_first(ser_msb), .converter_enable(conv_en),
        .converter_channel(conv_ch), .timer_capture_in(cap_in)
    );
    pin_load pin_load_a (.drive_out(a_out), .drive_oe(a_oe),
        .outside(a_outside), .heavy_load(heavy), .level(a_level));
    pin_load #(.width(3)) pin_load_b (.drive_out(b_out), .drive_oe(b_oe),
        .outside(b_outside), .heavy_load(heavy), .level(b_level));
    pin_load pin_load_c (.drive_out(c_out), .drive_oe(c_oe),
        .outside(c_outside), .heavy_load(heavy), .level(c_level));
    pin_load #(.width(1)) pin_load_d (.drive_out(d5_out), .drive_oe(d5_oe),
        .outside(d5_outside), .heavy_load(heavy), .level(d5_level));

    initial begin
        forever #5 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, want);
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        bus_request <= '{address: addr, write_data: data, write_strobe: 1'b1, read_strobe: 1'b0};
        @(posedge clock);
        bus_request <= '0;
        #1;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        bus_request <= '{address: addr, write_data: 8'h00, write_strobe: 1'b0, read_strobe: 1'b1};
        @(posedge clock);
        bus_request <= '0;
        #1;
        data = read_data;
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic reset_values();
        read_reg(8'h04, seen); check(seen, 8'h00);
        read_reg(8'h05, seen); check(seen, 8'h1F);
        read_reg(8'h06, seen); check(seen, 8'h00);
        read_reg(8'h07, seen); check(seen, 8'h00);
        read_reg(8'h08, seen); check(seen, 8'h00);
        check(a_oe | c_oe, 8'h00);
        check({4'h0, b_oe, d5_oe}, 8'h00);
        check({7'h00, ser_msb}, 8'h01);
    endtask

    task automatic port_a_io();
        write_reg(8'h00, 8'hA5);
        check(a_out, 8'hA5);
        read_reg(8'h00, seen); check(seen, 8'h3C);
        write_reg(8'h04, 8'hF0);
        check(a_oe, 8'hF0);
        @(posedge clock);
        heavy <= 1'b1;
        wait_cycles(4);
        read_reg(8'h00, seen); check(seen, 8'hAC);
        @(posedge clock);
        heavy <= 1'b0;
    endtask

    task automatic port_b_io();
        write_reg(8'h01, 8'hFF);
        write_reg(8'h05, 8'hFF);
        wait_cycles(1);
        check({5'h00, b_oe}, 8'h07);
        check({5'h00, b_out}, 8'h07);
        read_reg(8'h01, seen); check(seen, 8'hE0);
        read_reg(8'h05, seen); check(seen, 8'hFF);
        write_reg(8'h05, 8'h00);
        read_reg(8'h05, seen); check(seen, 8'h1F);
        @(posedge clock);
        b_outside <= 3'b010;
        wait_cycles(4);
        read_reg(8'h01, seen); check(seen, 8'h40);
        check({6'h00, ser_clk_in, ser_data_in}, 8'h01);
    endtask

    task automatic serial_share();
        @(posedge clock);
        ser_master <= 1'b1;
        ser_en <= 1'b1;
        ser_clk <= 1'b1;
        wait_cycles(3);
        read_reg(8'h05, seen); check(seen, 8'hBF);
        check({5'h00, b_oe}, 8'h05);
        check({5'h00, b_out[2], 1'b0, b_out[0]}, 8'h04);
        write_reg(8'h05, 8'h40);
        check({5'h00, b_oe}, 8'h02);
        read_reg(8'h05, seen); check(seen, 8'h5F);
        @(posedge clock);
        ser_en <= 1'b0;
        write_reg(8'h05, 8'hE0);
        wait_cycles(2);
        check({5'h00, b_out}, 8'h07);
        check({5'h00, b_oe}, 8'h07);
        @(posedge clock);
        ser_master <= 1'b0;
        ser_clk <= 1'b0;
        ser_en <= 1'b1;
        wait_cycles(3);
        check({5'h00, b_oe}, 8'h01);
        check({5'h00, b_out}, 8'h06);
        @(posedge clock);
        ser_en <= 1'b0;
    endtask

    task automatic converter_share();
        write_reg(8'h02, 8'h5A);
        check(c_out, 8'h5A);
        write_reg(8'h06, 8'h00);
        for (int n = 0; n < 4; n++) begin
            write_reg(8'h08, 8'h20 | 8'(n));
            wait_cycles(4);
            check({5'h00, conv_en, conv_ch}, 8'h04 | 8'(n));
            read_reg(8'h02, seen); check(seen, 8'hFF & ~(8'h08 << n));
        end
        write_reg(8'h06, 8'hFF);
        wait_cycles(1);
        check(c_oe, 8'h07);
        @(posedge clock);
        reset_n <= 1'b0;
        wait_cycles(2);
        reset_n <= 1'b1;
        wait_cycles(2);
        check({7'h00, conv_en}, 8'h00);
        check(c_oe, 8'h00);
        check(a_out, 8'hA5);
        read_reg(8'h08, seen); check(seen, 8'h00);
        read_reg(8'h02, seen); check(seen, 8'hFF);
    endtask

    task automatic port_d_io();
        write_reg(8'h03, 8'hFF);
        check({7'h00, d5_out}, 8'h01);
        @(posedge clock);
        cap_pin <= 1'b1;
        wait_cycles(4);
        read_reg(8'h03, seen); check(seen, 8'h90);
        check({7'h00, cap_in}, 8'h01);
        write_reg(8'h07, 8'hFF);
        check({7'h00, d5_oe}, 8'h01);
        read_reg(8'h07, seen); check(seen, 8'h20);
        read_reg(8'h03, seen); check(seen, 8'hB0);
        read_reg(8'h09, seen); check(seen, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        reset_values();
        port_a_io();
        port_b_io();
        serial_share();
        converter_share();
        port_d_io();
        report_and_stop();
    end
endmodule
`default_nettype wire
